// ==== verilog/two_wire_master_bus_state.sv ====
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module two_wire_master_bus_state #(
	parameter int unsigned TIMEOUT_CYC = two_wire_pkg::INACT_TIMEOUT_CYC
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_in_unused_n,
	input  wire logic        sda_dummy_unused_n,
	output logic             sda_out,
	output logic             sda_oe
);
	import two_wire_pkg::*;

	logic [2:0]      ctrl_r;
	logic            wr_pend_r;
	logic [7:0]      wr_addr_r;
	logic [31:0]     hrdata_r;
	logic            scl_m_r, scl_s, scl_q;
	logic            sda_m_r, sda_s, sda_q;
	logic [1:0]      bus_state_r;
	logic [3:0]      mon_bits_r;
	logic [TO_W-1:0] to_cnt_r;
	eng_state_t      est_r;
	logic [7:0]      tmr_r;
	logic [3:0]      bit_r;
	logic [7:0]      sh_r;
	logic [7:0]      addr_r;
	logic [7:0]      rx_byte_r;
	logic            rd_r, is_addr_r, ack_samp_r;
	logic            sda_drv_r, scl_drv_r;
	logic            wif_r, rif_r, rxack_r, arblost_r, buserr_r;
	logic            en, ap, w_ctrl, w_cmd, w_stat, w_addr, w_data;
	logic            start_det, stop_det, to_exp, force_idle, own_start_p;
	logic            in_byte, out_bit, bus_err_p, arb_lost_p, hi_end, fin, auto_rd;
	logic            own_bit;
	logic            set_wif, set_rif, clr_if, hold;
	status_t         wstat, rstat;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	assign en = ctrl_r[CTRL_EN];

	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	assign ap        = hsel && htrans[1] && hready && (hsize == SIZE_WORD);
	assign wstat     = status_t'(hwdata[$bits(status_t)-1:0]);
	assign w_ctrl    = wr_pend_r && (wr_addr_r == OFF_CTRL);
	assign w_cmd     = wr_pend_r && (wr_addr_r == OFF_CMD);
	assign w_stat    = wr_pend_r && (wr_addr_r == OFF_STATUS);
	assign w_addr    = wr_pend_r && (wr_addr_r == OFF_ADDR) && en;
	assign w_data    = wr_pend_r && (wr_addr_r == OFF_DATA) && en;
	assign force_idle = w_stat && en && (wstat.bus_state == BS_IDLE);

	always_comb
	begin
		rstat           = '0;
		rstat.bit_cnt   = mon_bits_r;
		rstat.bus_state = bus_state_r;
		rstat.buserr    = buserr_r;
		rstat.arblost   = arblost_r;
		rstat.rxack     = rxack_r;
		rstat.clkhold   = hold;
		rstat.wif       = wif_r;
		rstat.rif       = rif_r;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r  <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_r <= ap && hwrite;
			wr_addr_r <= haddr[7:0];
			hrdata_r  <= 32'h0000_0000;
			if (ap && !hwrite && (haddr[31:8] == 24'h00_0000))
			begin
				case (haddr[7:0])
					OFF_CTRL:   hrdata_r <= {29'h0000_0000, ctrl_r};
					OFF_STATUS: hrdata_r <= {20'h0_0000, rstat};
					OFF_ADDR:   hrdata_r <= {24'h00_0000, addr_r};
					OFF_DATA:   hrdata_r <= {24'h00_0000, rx_byte_r};
					default:    hrdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_r <= CTRL_RESET;
		else if (w_ctrl)
			ctrl_r <= hwdata[2:0];
	end

	// Line synchronisers, then one stage of history for edge detection
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			scl_m_r <= 1'b1;
			scl_s   <= 1'b1;
			scl_q   <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s   <= 1'b1;
			sda_q   <= 1'b1;
		end
		else
		begin
			scl_m_r <= scl_in;
			scl_s   <= scl_m_r;
			scl_q   <= scl_s;
			sda_m_r <= sda_in;
			sda_s   <= sda_m_r;
			sda_q   <= sda_s;
		end
	end

	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det  = scl_s && scl_q && !sda_q && sda_s;

	// Inactive-bus timer restarts on any line change
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			to_cnt_r <= '0;
		else if (!en || (scl_s != scl_q) || (sda_s != sda_q))
			to_cnt_r <= '0;
		else if (to_cnt_r != TO_W'(TIMEOUT_CYC))
			to_cnt_r <= to_cnt_r + 1'b1;
	end
	assign to_exp = ctrl_r[CTRL_TOEN] && (to_cnt_r == TO_W'(TIMEOUT_CYC - 1));

	// Bit counter of the monitor: clock rises since the last start or stop, back to 0 on every ninth rise
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mon_bits_r <= 4'h0;
		else if (!en || start_det || stop_det)
			mon_bits_r <= 4'h0;
		else if (scl_s && !scl_q)
			mon_bits_r <= (mon_bits_r == LAST_BIT) ? 4'h0 : mon_bits_r + 4'h1;
	end

	assign own_start_p = (est_r == E_WAIT_IDLE) && (bus_state_r == BS_IDLE);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bus_state_r <= BS_UNKNOWN;
		else if (!en)
			bus_state_r <= BS_UNKNOWN;
		else if (force_idle)
			bus_state_r <= BS_IDLE;
		else
		begin
			case (bus_state_r)
				BS_UNKNOWN:
					if (stop_det || to_exp)
						bus_state_r <= BS_IDLE;
				BS_IDLE:
					if (own_start_p)
						bus_state_r <= BS_OWNER;
					else if (start_det)
						bus_state_r <= BS_BUSY;
				BS_BUSY:
					if (stop_det || to_exp)
						bus_state_r <= BS_IDLE;
				BS_OWNER:
					if (arb_lost_p)
						bus_state_r <= BS_BUSY;
					else if (stop_det)
						bus_state_r <= BS_IDLE;
				default:
					bus_state_r <= BS_UNKNOWN;
			endcase
		end
	end

	// Bit being sent: receive data bits are released, ninth bit per role
	always_comb
	begin
		if (bit_r == LAST_BIT)
			out_bit = rd_r ? ctrl_r[CTRL_ACKACT] : 1'b1;
		else
			out_bit = rd_r ? 1'b1 : sh_r[7];
	end

	assign in_byte    = (est_r == E_LOW) || (est_r == E_WAIT_HIGH) || (est_r == E_HIGH);
	assign bus_err_p  = in_byte && (start_det || stop_det);
	// Only bits this master sends can lose; a slave's ack or data low is no collision
	assign own_bit    = ((bit_r == LAST_BIT) == rd_r);
	assign arb_lost_p = (est_r == E_WAIT_HIGH && scl_s && own_bit && out_bit && !sda_s)
		|| (est_r == E_RS_HIGH && scl_s && !sda_s)
		|| bus_err_p;
	assign hi_end  = (est_r == E_HIGH) && ((tmr_r == 8'h00) || !scl_s);
	assign fin     = hi_end && (bit_r == LAST_BIT) && !arb_lost_p;
	assign auto_rd = fin && is_addr_r && !ack_samp_r && addr_r[0];
	assign set_wif = (fin && !auto_rd && !rd_r) || (arb_lost_p && is_addr_r);
	assign set_rif = fin && rd_r;
	assign clr_if  = w_addr || w_data || w_cmd;
	assign hold    = (est_r == E_HOLD) && (wif_r || rif_r);

	// Byte engine
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			est_r      <= E_OFF;
			tmr_r      <= 8'h00;
			bit_r      <= 4'h0;
			sh_r       <= 8'h00;
			addr_r     <= 8'h00;
			rx_byte_r  <= 8'h00;
			rd_r       <= 1'b0;
			is_addr_r  <= 1'b0;
			ack_samp_r <= 1'b1;
			sda_drv_r  <= 1'b0;
			scl_drv_r  <= 1'b0;
		end
		else if (!en)
		begin
			est_r     <= E_OFF;
			sda_drv_r <= 1'b0;
			scl_drv_r <= 1'b0;
		end
		else if (arb_lost_p)
		begin
			est_r     <= E_OFF;
			sda_drv_r <= 1'b0;
			scl_drv_r <= 1'b0;
		end
		else
		begin
			if (tmr_r != 8'h00)
				tmr_r <= tmr_r - 8'h01;
			case (est_r)
				E_OFF:
					if (w_addr)
					begin
						addr_r <= hwdata[7:0];
						est_r  <= E_WAIT_IDLE;
					end
				E_WAIT_IDLE:
					if (bus_state_r == BS_IDLE)
					begin
						sda_drv_r <= 1'b1;
						tmr_r     <= HIGH_LOAD;
						est_r     <= E_START;
					end
				E_START:
					if (tmr_r == 8'h00)
					begin
						scl_drv_r <= 1'b1;
						tmr_r     <= LOW_LOAD;
						bit_r     <= 4'h0;
						sh_r      <= addr_r;
						is_addr_r <= 1'b1;
						rd_r      <= 1'b0;
						est_r     <= E_LOW;
					end
				E_LOW:
				begin
					sda_drv_r <= !out_bit;
					if (tmr_r == 8'h00)
					begin
						scl_drv_r <= 1'b0;
						est_r     <= E_WAIT_HIGH;
					end
				end
				E_WAIT_HIGH:
					if (scl_s)
					begin
						tmr_r <= HIGH_LOAD;
						est_r <= E_HIGH;
						if (bit_r == LAST_BIT)
							ack_samp_r <= sda_s;
						else
							sh_r <= {sh_r[6:0], sda_s};
					end
				E_HIGH:
					if (hi_end)
					begin
						scl_drv_r <= 1'b1;
						tmr_r     <= LOW_LOAD;
						if (bit_r != LAST_BIT)
						begin
							bit_r <= bit_r + 4'h1;
							est_r <= E_LOW;
						end
						else if (auto_rd)
						begin
							bit_r     <= 4'h0;
							is_addr_r <= 1'b0;
							rd_r      <= 1'b1;
							est_r     <= E_LOW;
						end
						else
						begin
							sda_drv_r <= 1'b0;
							// The flags hold the clock from here, so clearing them releases it
							scl_drv_r <= 1'b0;
							if (rd_r)
								rx_byte_r <= sh_r;
							est_r <= E_HOLD;
						end
					end
				E_HOLD:
					if (w_data)
					begin
						sh_r      <= hwdata[7:0];
						bit_r     <= 4'h0;
						is_addr_r <= 1'b0;
						rd_r      <= 1'b0;
						scl_drv_r <= 1'b1;
						tmr_r     <= LOW_LOAD;
						est_r     <= E_LOW;
					end
					else if (w_cmd && hwdata[1:0] == CMD_RECV)
					begin
						bit_r     <= 4'h0;
						is_addr_r <= 1'b0;
						rd_r      <= 1'b1;
						scl_drv_r <= 1'b1;
						tmr_r     <= LOW_LOAD;
						est_r     <= E_LOW;
					end
					else if (w_cmd && hwdata[1:0] == CMD_STOP)
					begin
						scl_drv_r <= 1'b1;
						sda_drv_r <= 1'b1;
						tmr_r     <= LOW_LOAD;
						est_r     <= E_STOP_LOW;
					end
					else if (w_addr)
					begin
						addr_r    <= hwdata[7:0];
						scl_drv_r <= 1'b1;
						sda_drv_r <= 1'b0;
						tmr_r     <= LOW_LOAD;
						est_r     <= E_RS_LOW;
					end
				E_STOP_LOW, E_RS_LOW:
					if (tmr_r == 8'h00)
					begin
						scl_drv_r <= 1'b0;
						tmr_r     <= HIGH_LOAD;
						est_r     <= (est_r == E_STOP_LOW) ? E_STOP_HIGH : E_RS_HIGH;
					end
				E_STOP_HIGH, E_RS_HIGH:
					if (!scl_s)
						tmr_r <= HIGH_LOAD;
					else if (tmr_r == 8'h00)
					begin
						sda_drv_r <= (est_r == E_RS_HIGH);
						tmr_r     <= HIGH_LOAD;
						est_r     <= (est_r == E_RS_HIGH) ? E_START : E_OFF;
					end
				default:
					est_r <= E_OFF;
			endcase
		end
	end

	// Flags: a hardware set in the same cycle as a clear wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wif_r     <= 1'b0;
			rif_r     <= 1'b0;
			rxack_r   <= 1'b0;
			arblost_r <= 1'b0;
			buserr_r  <= 1'b0;
		end
		else if (!en)
		begin
			wif_r     <= 1'b0;
			rif_r     <= 1'b0;
			rxack_r   <= 1'b0;
			arblost_r <= 1'b0;
			buserr_r  <= 1'b0;
		end
		else
		begin
			wif_r     <= set_wif || (wif_r && !clr_if && !(w_stat && wstat.wif));
			rif_r     <= set_rif || (rif_r && !clr_if && !(w_stat && wstat.rif));
			arblost_r <= arb_lost_p || (arblost_r && !(w_stat && wstat.arblost));
			buserr_r  <= bus_err_p || (buserr_r && !(w_stat && wstat.buserr));
			if (fin && !auto_rd)
				rxack_r <= !rd_r && ack_samp_r;
		end
	end

	// Open-drain pins: drive low only
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe  = scl_drv_r || hold;
	assign sda_oe  = sda_drv_r;
	assign sda_in_unused_n = sda_dummy_unused_n;

	sequence own_start_s;
		own_start_p && !force_idle;
	endsequence
	sequence addr_loss_s;
		arb_lost_p && is_addr_r && en;
	endsequence
	sequence addr_nack_s;
		fin && is_addr_r && !addr_r[0] && ack_samp_r && en;
	endsequence

	lost_drive_a: assert property (arb_lost_p |=> !sda_oe)
		else $error("data line still driven after arbitration loss");
	sync_wait_a: assert property ((est_r == E_WAIT_HIGH && !scl_s) |-> !scl_drv_r ##1 est_r != E_HIGH)
		else $error("high period began before clock line rose");
	disable_unknown_a: assert property (!en |=> bus_state_r == BS_UNKNOWN)
		else $error("bus state not unknown while disabled");
	stop_idle_a: assert property ((en && bus_state_r == BS_UNKNOWN && stop_det) |=> (bus_state_r == BS_IDLE || !en))
		else $error("first stop did not give idle");
	timeout_idle_a: assert property ((en && to_exp && bus_state_r == BS_BUSY) |=> (bus_state_r == BS_IDLE || !en))
		else $error("timeout did not give idle from busy");
	ext_start_a: assert property ((en && bus_state_r == BS_IDLE && start_det && !own_start_p && !force_idle) |=> (bus_state_r == BS_BUSY || !en))
		else $error("foreign start did not give busy");
	owner_a: assert property (own_start_s |=> (bus_state_r == BS_OWNER || !en))
		else $error("own start did not give owner");
	arb_busy_a: assert property ((en && bus_state_r == BS_OWNER && arb_lost_p && !force_idle) |=> (bus_state_r == BS_BUSY || !en))
		else $error("loss while owner did not give busy");
	hold_clock_a: assert property (($rose(wif_r || rif_r) && !$past(arb_lost_p)) |-> scl_oe)
		else $error("flag set without clock hold");
	addr_loss_a: assert property (addr_loss_s |=> (wif_r && arblost_r && !sda_oe && !scl_oe) || !en)
		else $error("address loss flags or release wrong");
	addr_nack_a: assert property (addr_nack_s |=> (wif_r && rxack_r && scl_oe) || !en)
		else $error("address nack not flagged with hold");
endmodule

// ==== verilog/two_wire_pkg.sv ====
package two_wire_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CMD    = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_ADDR   = 8'h0c;
	localparam logic [7:0] OFF_DATA   = 8'h10;
	localparam logic [2:0] SIZE_WORD  = 3'h2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// Control bit positions
	localparam int CTRL_EN     = 0;
	localparam int CTRL_TOEN   = 1;
	localparam int CTRL_ACKACT = 2;
	// Command codes
	localparam logic [1:0] CMD_RECV = 2'h2;
	localparam logic [1:0] CMD_STOP = 2'h3;
	// Bus state codes
	localparam logic [1:0] BS_UNKNOWN = 2'h0;
	localparam logic [1:0] BS_IDLE    = 2'h1;
	localparam logic [1:0] BS_OWNER   = 2'h2;
	localparam logic [1:0] BS_BUSY    = 2'h3;
	// Bit counting: eight data bits then the acknowledge bit
	localparam logic [3:0] LAST_BIT = 4'h8;
	// Timing
	localparam int CLK_PERIOD_NS     = 40;
	localparam int SCL_LOW_NS        = 5000;
	localparam int SCL_HIGH_NS       = 4000;
	localparam int INACT_TIMEOUT_US  = 200;
	localparam int LOW_CYC_I  = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HIGH_CYC_I = (SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] LOW_LOAD  = 8'(LOW_CYC_I - 1);
	localparam logic [7:0] HIGH_LOAD = 8'(HIGH_CYC_I - 1);
	localparam int unsigned INACT_TIMEOUT_CYC = INACT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
	localparam int TO_W = 16;

	typedef struct packed {
		logic [3:0] bit_cnt;
		logic [1:0] bus_state;
		logic       buserr;
		logic       arblost;
		logic       rxack;
		logic       clkhold;
		logic       wif;
		logic       rif;
	} status_t;

	typedef enum logic [3:0] {
		E_OFF, E_WAIT_IDLE, E_START, E_LOW, E_WAIT_HIGH, E_HIGH,
		E_HOLD, E_STOP_LOW, E_STOP_HIGH, E_RS_LOW, E_RS_HIGH
	} eng_state_t;
endpackage

// ==== test/two_wire_slave_model.sv ====
`timescale 1ns/1ps
module two_wire_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
)
(
	input  wire logic       hclk,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       stretch,
	input  wire logic       jam,
	input  wire logic [7:0] rd_byte,
	output logic            sda_oe,
	output logic            scl_oe,
	output logic      [7:0] got
);
	logic       ps, pd, first, m, rd, a9, tx;
	logic [7:0] sh;
	int         n, st, jt;
	initial
	begin
		{ps, pd, first, m, rd, a9, tx, sda_oe, scl_oe} = '0;
		{sh, got} = '0;
		{n, st, jt} = '0;
	end
	always @(posedge hclk)
	begin
		ps <= scl;
		pd <= sda;
		if (st == 1)
			scl_oe <= 1'b0;
		if (st > 0)
			st <= st - 1;
		// Competing master lets go of data a while after winning
		if (jt == 1)
			sda_oe <= 1'b0;
		if (jt > 0)
			jt <= jt - 1;
		if (ps && scl && pd && !sda)
		begin
			first <= 1'b1;
			m <= 1'b0;
			tx <= 1'b0;
			n <= 0;
		end
		else if (ps && scl && !pd && sda)
		begin
			m <= 1'b0;
			tx <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (!ps && scl)
		begin
			if (n < 8)
				sh <= {sh[6:0], sda};
			else
				a9 <= sda;
			n <= (n == 8) ? 0 : n + 1;
		end
		else if (ps && !scl)
		begin
			if (stretch)
			begin
				scl_oe <= 1'b1;
				st <= 300;
			end
			if (n == 8)
			begin
				first <= 1'b0;
				if (first)
				begin
					m <= sh[7:1] == ADDR;
					rd <= sh[0];
					sda_oe <= sh[7:1] == ADDR;
				end
				else
				begin
					if (m && !rd)
						got <= sh;
					sda_oe <= m && !rd;
				end
			end
			else if (n == 0)
			begin
				tx <= m && rd && !a9;
				sda_oe <= m && rd && !a9 && !rd_byte[7];
			end
			else if (tx)
				sda_oe <= !rd_byte[7 - n];
			else if (jam && first && n == 1)
			begin
				sda_oe <= 1'b1;
				jt <= 600;
			end
		end
	end
endmodule

// ==== test/test_two_wire_master_bus_state.sv ====
`timescale 1ns/1ps
module test_two_wire_master_bus_state;
	import two_wire_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, stretch, jam, t_sda, t_scl;
	logic [31:0] haddr, hwdata, hrdata, s;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, scl_o, d_scl_oe, sda_o, d_sda_oe, m_scl, m_sda;
	logic [7:0]  got;
	wire         scl, sda;
	int          n_errors, checks, cyc, hi, min_hi;
	assign scl = !(d_scl_oe || m_scl || t_scl);
	assign sda = !(d_sda_oe || m_sda || t_sda);
	two_wire_master_bus_state #(
		.TIMEOUT_CYC(50)
	) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl),
		.scl_out(scl_o), .scl_oe(d_scl_oe), .sda_in(sda), .sda_in_unused_n(),
		.sda_dummy_unused_n(1'b0), .sda_out(sda_o), .sda_oe(d_sda_oe)
	);
	two_wire_slave_model peer (
		.hclk(hclk), .scl(scl), .sda(sda), .stretch(stretch), .jam(jam),
		.rd_byte(8'hc3), .sda_oe(m_sda), .scl_oe(m_scl), .got(got)
	);
	initial
	begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	task automatic stop_test;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Shortest clock high run on the line, and the hang limit
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (scl)
			hi <= hi + 1;
		else
		begin
			if (hi > 0 && hi < min_hi)
				min_hi <= hi;
			hi <= 0;
		end
		if (cyc == 60000)
		begin
			n_errors = n_errors + 1;
			stop_test;
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks = checks + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		s = hrdata;
	endtask
	task automatic wait_st(input logic [31:0] mk, input logic [31:0] v);
		int i;
		for (i = 0; i < 3000; i++)
		begin
			bus(1'b0, OFF_STATUS, 32'h0);
			if ((s & mk) === v)
				break;
		end
		chk("status", v, s & mk);
	endtask
	task automatic bs_is(input logic [1:0] e);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk("bus_state", {30'h0, e}, {30'h0, s[7:6]});
	endtask
	task automatic bit_is(input int b, input logic e);
		chk("status_bit", {31'h0, e}, {31'h0, s[b]});
	endtask
	task automatic bus_start;
		t_sda <= 1'b1;
		tick(10);
	endtask
	task automatic bus_stop;
		t_sda <= 1'b0;
		tick(10);
	endtask
	// Leaves both lines high again without any stop
	task automatic bus_drop;
		t_scl <= 1'b1;
		tick(10);
		t_sda <= 1'b0;
		tick(10);
		t_scl <= 1'b0;
		tick(10);
	endtask
	task automatic t_reset;
		bus(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl", 32'h0, s);
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, s);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("pin_out", 32'h0, {30'h0, scl_o, sda_o});
		bs_is(BS_UNKNOWN);
		$display("t_reset done");
	endtask
	task automatic t_state;
		bus(1'b1, OFF_CTRL, 32'h1);
		bs_is(BS_UNKNOWN);
		bus(1'b1, OFF_STATUS, 32'h40);
		bs_is(BS_IDLE);
		bus(1'b1, OFF_CTRL, 32'h0);
		bs_is(BS_UNKNOWN);
		bus(1'b1, OFF_CTRL, 32'h1);
		bs_is(BS_UNKNOWN);
		bus_start;
		bus_stop;
		bs_is(BS_IDLE);
		bus_start;
		bs_is(BS_BUSY);
		bus_drop;
		tick(80);
		bs_is(BS_BUSY);
		bus_start;
		bus_stop;
		bs_is(BS_IDLE);
		$display("t_state done");
	endtask
	task automatic t_timeout;
		bus(1'b1, OFF_CTRL, 32'h0);
		bus(1'b1, OFF_CTRL, 32'h3);
		bs_is(BS_UNKNOWN);
		tick(80);
		bs_is(BS_IDLE);
		bus_start;
		bs_is(BS_BUSY);
		bus_drop;
		tick(80);
		bs_is(BS_IDLE);
		$display("t_timeout done");
	endtask
	task automatic t_write;
		min_hi <= 999;
		bus(1'b1, OFF_ADDR, 32'h54);
		tick(10);
		bs_is(BS_OWNER);
		wait_st(32'h2, 32'h2);
		bit_is(3, 1'b0);
		bit_is(2, 1'b1);
		chk("scl_line", 32'h0, {31'h0, scl});
		stretch <= 1'b1;
		bus(1'b1, OFF_DATA, 32'ha5);
		wait_st(32'h2, 32'h2);
		stretch <= 1'b0;
		bit_is(3, 1'b0);
		chk("rx_byte", 32'ha5, {24'h0, got});
		chk("min_high", 32'h1, {31'h0, min_hi >= 99});
		bus(1'b1, OFF_ADDR, 32'h54);
		wait_st(32'h2, 32'h2);
		bs_is(BS_OWNER);
		bit_is(3, 1'b0);
		bus(1'b1, OFF_CMD, {30'h0, CMD_STOP});
		wait_st(32'hc0, 32'h40);
		$display("t_write done");
	endtask
	task automatic t_nack;
		bus(1'b1, OFF_ADDR, 32'h66);
		wait_st(32'h2, 32'h2);
		bit_is(3, 1'b1);
		bit_is(2, 1'b1);
		bus(1'b1, OFF_STATUS, 32'h33);
		tick(10);
		chk("scl_line", 32'h1, {31'h0, scl});
		bus(1'b1, OFF_CMD, {30'h0, CMD_STOP});
		wait_st(32'hc0, 32'h40);
		$display("t_nack done");
	endtask
	task automatic t_read;
		bus(1'b1, OFF_CTRL, 32'h7);
		bus(1'b1, OFF_ADDR, 32'h55);
		wait_st(32'h1, 32'h1);
		bit_is(3, 1'b0);
		bus(1'b0, OFF_DATA, 32'h0);
		chk("rd_byte", 32'hc3, s);
		bus(1'b1, OFF_CMD, {30'h0, CMD_STOP});
		wait_st(32'hc0, 32'h40);
		$display("t_read done");
	endtask
	task automatic t_arb;
		bus(1'b1, OFF_CTRL, 32'h1);
		jam <= 1'b1;
		bus(1'b1, OFF_ADDR, 32'h54);
		wait_st(32'h2, 32'h2);
		bit_is(4, 1'b1);
		bs_is(BS_BUSY);
		chk("dut_oe", 32'h0, {30'h0, d_scl_oe, d_sda_oe});
		jam <= 1'b0;
		bus(1'b1, OFF_STATUS, 32'h13);
		bus(1'b1, OFF_ADDR, 32'h54);
		tick(20);
		bs_is(BS_BUSY);
		wait_st(32'h2, 32'h2);
		bit_is(3, 1'b0);
		bus(1'b1, OFF_CMD, {30'h0, CMD_STOP});
		wait_st(32'hc0, 32'h40);
		$display("t_arb done");
	endtask
	initial
	begin
		{hresetn, hsel, hwrite, stretch, jam, t_sda, t_scl} = '0;
		{haddr, hwdata} = '0;
		htrans = 2'h0;
		hsize = SIZE_WORD;
		{n_errors, checks, cyc, hi} = '0;
		min_hi = 999;
		tick(3);
		hresetn <= 1'b1;
		hsel <= 1'b1;
		t_reset;
		t_state;
		t_timeout;
		t_write;
		t_nack;
		t_read;
		t_arb;
		stop_test;
	end
endmodule
